// >>> rtl/rsc_reset_source_controller.sv
// reset source controller: collects reset sources, keeps the cause register
//
// Functional notes
// R1 - stuck clock over 100 us resets
// R2 - clock loss flag bit 2 after it
// R3 - bit 2 write enables clock loss detector
// R4 - clock loss off in low power, restored
// R5 - internal resets never drive reset pin
// R6 - bit 5 enables comparator, flags its reset
// R7 - comparator low input holds reset
// R8 - comparator works in low power if wake
// R9 - software settles comparator before enabling
// R10 - watchdog enabled, clocked by clock/12 after reset
// R11 - watchdog overflow resets, flag bit 3
// R12 - watchdog reset off in low power, restored
// R13 - illegal flash accesses reset the device
// R14 - flash fault flag bit 6 after it
// R15 - rtc alarm or osc fail resets, bit 7
// R16 - rtc reset works in low power
// R17 - writing bit 4 forces reset, flags it
// R18 - bit 1 enables supply monitor reset
// R19 - power flag set makes others meaningless
// R20 - pin reset flag bit 0
// R21 - read modify write leaves other bits alone; reads return flags here, and writing back flag bit 4 forces a reset
// R22 - software lets monitor settle before enabling
// R23 - each reset leaves only its causes flagged
`timescale 1ns/1ns

module rsc_reset_source_controller #(
  parameter int MCD_CYC = rsc_pkg::RSC_MCD_CYC  // clock loss timeout in cycles
) (
  input  wire logic            clk_sys,      // system clock
  input  wire logic            rstn,         // power-on reset, active low
  input  wire rsc_pkg::rsc_sfr_t sfr,        // register access
  input  wire rsc_pkg::rsc_flash_t flash,    // flash access monitor
  input  wire logic [15:0]     lock_addr,    // lock byte address
  input  wire logic            mon_clk,      // monitored system clock level
  input  wire logic            cmp_out,      // comparator output, pin domain
  input  wire logic            cmp_wake_en,  // comparator is a wake source
  input  wire logic            vdd_ok,       // supply above threshold
  input  wire logic            rst_pin_i,    // reset pin level
  input  wire logic            wdt_ovf,      // watchdog overflow pulse
  input  wire logic            wdt_disable,  // software turned watchdog off
  input  wire logic            rtc_alarm,    // rtc alarm match pulse
  input  wire logic            rtc_osc_fail, // rtc oscillator failed
  input  wire logic            low_power,    // suspend or sleep active
  output logic                 sys_rst,      // system reset, active high
  output logic [7:0]           sfr_rdata,    // read data
  output logic                 wdt_en,       // watchdog enable
  output logic                 wdt_tick,     // watchdog clock pulse
  output logic                 rst_pin_o,    // reset pin drive value
  output logic                 rst_pin_oe    // reset pin drive enable
);
  import rsc_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (MCD_CYC < 1 || MCD_CYC > 65535) begin : g_bad_mcd
    $error("MCD_CYC must fit the 16 bit counter");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // access beyond the user code space
  function automatic logic above_lock(input logic [15:0] a,
                                      input logic [15:0] lk);
    above_lock = (a > lk);
  endfunction : above_lock

  // three stage sync; level moves only when stages two and three agree
  function automatic logic sync_lvl(input logic [2:0] s, input logic l);
    sync_lvl = (s[1] == s[2]) ? s[2] : l;
  endfunction : sync_lvl

  rsc_state_t  state_q;
  rsc_state_t  state_d;
  logic [7:0]  cause;
  logic        wr_hit;
  logic        mon_edge;
  logic        flash_err;

  // ----------------------------------------------------------------
  // reset causes, aligned with the register bits
  // ----------------------------------------------------------------
  always_comb begin
    wr_hit    = sfr.wr && (sfr.addr == RSC_CAUSE_ADDR);
    mon_edge  = (state_q.mon_s[1] == state_q.mon_s[2]) &&
                (state_q.mon_s[2] != state_q.mon_l);
    // any illegal flash access resets
    flash_err = (flash.wr && flash.wr_en && above_lock(flash.addr, lock_addr)) || // R13
                (flash.rd && above_lock(flash.addr, lock_addr)) ||               // R13
                (flash.fetch && above_lock(flash.addr, lock_addr)) ||            // R13
                flash.sec_deny ||                                                // R13
                (flash.wr && !flash.vdm_on);                                     // R13
    cause = 8'h00;
    cause[RSC_B_RTC]   = state_q.en_rtc && (rtc_alarm || rtc_osc_fail);  // R15 R16
    cause[RSC_B_FLASH] = flash_err;                                      // R14
    // comparator survives low power only as a wake source
    cause[RSC_B_CMP]   = state_q.en_cmp && !state_q.cmp_l &&
                         (!low_power || cmp_wake_en);                     // R7 R8
    cause[RSC_B_SW]    = wr_hit && sfr.wdata[RSC_B_SW] &&
                         (state_q.st == RSC_RUN);                         // R17
    cause[RSC_B_WDT]   = wdt_ovf && state_q.wdt_en && !low_power;        // R11 R12
    cause[RSC_B_MCD]   = state_q.en_mcd && !low_power &&
                         (state_q.mcd_cnt == 16'(MCD_CYC));               // R1 R4
    cause[RSC_B_PWR]   = state_q.en_vdm && !state_q.vdd_l;               // R18
    cause[RSC_B_PIN]   = !state_q.pin_l;                                 // R20
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    // pin and foreign-domain inputs
    state_d.pin_s = {state_q.pin_s[1:0], rst_pin_i};
    state_d.cmp_s = {state_q.cmp_s[1:0], cmp_out};
    state_d.vdd_s = {state_q.vdd_s[1:0], vdd_ok};
    state_d.mon_s = {state_q.mon_s[1:0], mon_clk};
    state_d.pin_l = sync_lvl(state_q.pin_s, state_q.pin_l);
    state_d.cmp_l = sync_lvl(state_q.cmp_s, state_q.cmp_l);
    state_d.vdd_l = sync_lvl(state_q.vdd_s, state_q.vdd_l);
    state_d.mon_l = sync_lvl(state_q.mon_s, state_q.mon_l);

    // time since the monitored clock last changed level
    if (mon_edge) begin
      state_d.mcd_cnt = 16'h0000;                                 // R1
    end else if (state_q.mcd_cnt != 16'(MCD_CYC)) begin
      state_d.mcd_cnt = state_q.mcd_cnt + 16'h0001;              // R1
    end

    // watchdog clock divider, held clear in reset
    state_d.wdt_tick = 1'b0;
    if (state_q.sys_rst) begin
      state_d.div = 4'h0;
    end else if (state_q.div == RSC_WDT_DIV_LAST) begin
      state_d.div      = 4'h0;                                    // R10
      state_d.wdt_tick = 1'b1;                                    // R10
    end else begin
      state_d.div = state_q.div + 4'h1;
    end

    // watchdog comes back enabled after every reset
    if (state_q.sys_rst) begin
      state_d.wdt_en = 1'b1;                                      // R10
    end else if (wdt_disable) begin
      state_d.wdt_en = 1'b0;
    end

    // registered read port; flags are never touched by a read
    state_d.rdata = (sfr.rd && sfr.addr == RSC_CAUSE_ADDR) ? state_q.flags : 8'h00;

    // the pin is input only for this block
    state_d.pin_o  = 1'b0;                                        // R5
    state_d.pin_oe = 1'b0;                                        // R5

    unique case (state_q.st)
      RSC_RUN: begin
        // writes change enables only, but a read-modify-write that writes back flag bit 4 forces a software reset
        if (wr_hit) begin
          state_d.en_rtc = sfr.wdata[RSC_B_RTC];                  // R15 R21
          state_d.en_cmp = sfr.wdata[RSC_B_CMP];                  // R6 R21
          state_d.en_mcd = sfr.wdata[RSC_B_MCD];                  // R3 R21
          state_d.en_vdm = sfr.wdata[RSC_B_PWR];                  // R18 R21
        end
        if (|cause) begin
          state_d.st      = RSC_HOLD;
          state_d.hold    = RSC_HOLD_LAST;
          state_d.flags   = cause;                                // R23
          // one-shot re-arms, so a clock that stays stopped waits a full timeout again
          state_d.mcd_cnt = 16'h0000;                             // R1
          state_d.sys_rst = 1'b1;
        end
      end
      RSC_HOLD: begin
        // sources active during the pulse share the blame
        state_d.flags = state_q.flags | cause;                    // R23
        if (|cause) begin
          state_d.hold = RSC_HOLD_LAST;                           // R7
        end else if (state_q.hold == 4'h0) begin
          state_d.st      = RSC_RUN;
          state_d.sys_rst = 1'b0;
        end else begin
          state_d.hold = state_q.hold - 4'h1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // power-on reset loads RSC_RST_STATE, a reset pulse with the power flag set; system resets keep the source enables and re-enable the watchdog
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= RSC_RST_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sys_rst    = state_q.sys_rst;
  assign sfr_rdata  = state_q.rdata;
  assign wdt_en     = state_q.wdt_en;
  assign wdt_tick   = state_q.wdt_tick;
  assign rst_pin_o  = state_q.pin_o;
  assign rst_pin_oe = state_q.pin_oe;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic run_q;
  assign run_q = (state_q.st == RSC_RUN);

  // reset taken with the given flag set
  sequence enter_rst(int b);
    state_q.sys_rst && state_q.flags[b];
  endsequence

  // a write that only changes enables
  sequence quiet_write;
    run_q && wr_hit && !sfr.wdata[RSC_B_SW] && (cause == 8'h00);
  endsequence

  sw_force_a: assert property ( // R17
    run_q && wr_hit && sfr.wdata[RSC_B_SW] |=> enter_rst(RSC_B_SW))
    else $error("software force did not reset");

  mcd_timeout_a: assert property ( // R1 R2 R3
    run_q && state_q.en_mcd && !low_power &&
    state_q.mcd_cnt == 16'(MCD_CYC) |=> enter_rst(RSC_B_MCD))
    else $error("clock loss timeout missed");

  mcd_sleep_a: assert property ( // R4 R12
    low_power |-> !cause[RSC_B_MCD] && !cause[RSC_B_WDT])
    else $error("gated source active in low power");

  cmp_low_a: assert property ( // R6 R7 R8
    run_q && state_q.en_cmp && !state_q.cmp_l &&
    (!low_power || cmp_wake_en) |=> enter_rst(RSC_B_CMP))
    else $error("comparator reset missed");

  wdt_ovf_a: assert property ( // R11
    run_q && wdt_ovf && state_q.wdt_en && !low_power |=> enter_rst(RSC_B_WDT))
    else $error("watchdog overflow reset missed");

  wdt_div_a: assert property ( // R10
    state_q.wdt_tick && !state_q.sys_rst |=> (!state_q.wdt_tick) [*8])
    else $error("watchdog clock too fast");

  wdt_up_a: assert property ( // R10
    $fell(state_q.sys_rst) |-> state_q.wdt_en)
    else $error("watchdog not enabled after reset");

  flash_err_a: assert property ( // R13 R14
    run_q && flash_err |=> enter_rst(RSC_B_FLASH))
    else $error("flash fault reset missed");

  rtc_src_a: assert property ( // R15 R16
    run_q && state_q.en_rtc && (rtc_alarm || rtc_osc_fail) |=> enter_rst(RSC_B_RTC))
    else $error("rtc reset missed");

  vdm_src_a: assert property ( // R18
    run_q && state_q.en_vdm && !state_q.vdd_l |=> enter_rst(RSC_B_PWR))
    else $error("supply monitor reset missed");

  pin_src_a: assert property ( // R20
    run_q && !state_q.pin_l |=> enter_rst(RSC_B_PIN))
    else $error("pin reset missed");

  rmw_keep_a: assert property ( // R21
    quiet_write |=> state_q.flags == $past(state_q.flags))
    else $error("write disturbed cause flags");

  only_cause_a: assert property ( // R23
    $rose(state_q.sys_rst) |-> state_q.flags == $past(cause))
    else $error("cause flags not replaced");

  pin_quiet_a: assert property ( // R5
    state_q.sys_rst |-> !rst_pin_oe)
    else $error("reset pin driven");

  // register read hit
  sequence rd_hit;
    sfr.rd && (sfr.addr == RSC_CAUSE_ADDR);
  endsequence

  rd_data_a: assert property ( // R21
    rd_hit |=> sfr_rdata == $past(state_q.flags))
    else $error("read data is not the cause flags");

  rd_idle_a: assert property ( // R21
    !(sfr.rd && (sfr.addr == RSC_CAUSE_ADDR)) |=> sfr_rdata == 8'h00)
    else $error("read data not idle");

  en_write_a: assert property ( // R3 R6 R15 R18
    run_q && wr_hit |=> {state_q.en_rtc, state_q.en_cmp, state_q.en_mcd, state_q.en_vdm} ==
    $past({sfr.wdata[RSC_B_RTC], sfr.wdata[RSC_B_CMP], sfr.wdata[RSC_B_MCD], sfr.wdata[RSC_B_PWR]}))
    else $error("enable write lost");

  wr_hold_a: assert property ( // R21
    !run_q && wr_hit |=>
    $stable({state_q.en_rtc, state_q.en_cmp, state_q.en_mcd, state_q.en_vdm}))
    else $error("write taken during reset");

  hold_len_a: assert property ( // R23
    $fell(state_q.sys_rst) |-> $past(state_q.sys_rst, 8))
    else $error("reset pulse too short");

  mcd_rearm_a: assert property ( // R1
    mon_edge |=> state_q.mcd_cnt == 16'h0000)
    else $error("clock loss timer not restarted");

  mcd_count_a: assert property ( // R1
    !mon_edge && !(run_q && (|cause)) && state_q.mcd_cnt != 16'(MCD_CYC) |=>
    state_q.mcd_cnt == $past(state_q.mcd_cnt) + 16'h0001)
    else $error("clock loss timer stalled");

  flags_keep_a: assert property ( // R21 R23
    run_q && !(|cause) |=> $stable(state_q.flags))
    else $error("cause flags changed without a reset");

  hold_or_a: assert property ( // R23
    !run_q |=> (state_q.flags & $past(state_q.flags)) == $past(state_q.flags))
    else $error("cause flag lost during reset");

  pin_drive_a: assert property ( // R5
    !rst_pin_oe && !rst_pin_o)
    else $error("reset pin output active");

  wdt_tick_rst_a: assert property ( // R10
    state_q.sys_rst |=> !state_q.wdt_tick)
    else $error("watchdog clock ran in reset");

  wdt_first_a: assert property ( // R10
    $fell(state_q.sys_rst) |-> state_q.div == 4'h0)
    else $error("watchdog divider not restarted");

  sw_refused_a: assert property ( // R17
    !run_q |-> !cause[RSC_B_SW])
    else $error("software force taken during reset");

endmodule : rsc_reset_source_controller

// >>> include/rsc_pkg.sv
// constants, carriers and state layout for the reset source controller
package rsc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RSC_CAUSE_ADDR = 8'hEF;  // reset_cause_register
  localparam int         RSC_B_PIN      = 0;      // pin reset flag
  localparam int         RSC_B_PWR      = 1;      // power flag / monitor enable
  localparam int         RSC_B_MCD      = 2;      // clock loss enable / flag
  localparam int         RSC_B_WDT      = 3;      // watchdog flag
  localparam int         RSC_B_SW       = 4;      // software force / flag
  localparam int         RSC_B_CMP      = 5;      // comparator enable / flag
  localparam int         RSC_B_FLASH    = 6;      // flash fault flag
  localparam int         RSC_B_RTC      = 7;      // rtc enable / flag

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int RSC_CLK_NS  = 4;       // system clock period
  localparam int RSC_MCD_NS  = 100000;  // clock stuck time before timeout
  // least time, so round up
  localparam int RSC_MCD_CYC = (RSC_MCD_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
  localparam logic [3:0] RSC_WDT_DIV_LAST = 4'hB;  // divide by 12
  localparam logic [3:0] RSC_HOLD_LAST    = 4'h7;  // 8 cycle reset pulse

  // ----------------------------------------------------------------
  // carriers and state
  // ----------------------------------------------------------------
  typedef enum logic {RSC_RUN = 1'b0, RSC_HOLD = 1'b1} rsc_st_t;

  typedef struct packed {
    logic       wr;     // write strobe
    logic       rd;     // read strobe
    logic [7:0] addr;   // register address
    logic [7:0] wdata;  // write data
  } rsc_sfr_t;

  typedef struct packed {
    logic        wr;        // flash write or erase attempt
    logic        rd;        // code_move_instr read
    logic        fetch;     // instruction fetch
    logic        wr_en;     // flash_write_enable
    logic        sec_deny;  // security denied the access
    logic        vdm_on;    // supply monitor running
    logic [15:0] addr;      // target address
  } rsc_flash_t;

  typedef struct packed {
    rsc_st_t     st;
    logic [3:0]  hold;
    logic [7:0]  flags;
    logic        en_mcd;
    logic        en_cmp;
    logic        en_rtc;
    logic        en_vdm;
    logic [2:0]  pin_s;
    logic [2:0]  cmp_s;
    logic [2:0]  vdd_s;
    logic [2:0]  mon_s;
    logic        pin_l;
    logic        cmp_l;
    logic        vdd_l;
    logic        mon_l;
    logic [15:0] mcd_cnt;
    logic [3:0]  div;
    logic        wdt_en;
    logic        wdt_tick;
    logic        sys_rst;
    logic [7:0]  rdata;
    logic        pin_o;
    logic        pin_oe;
  } rsc_state_t;

  localparam rsc_state_t RSC_RST_STATE = '{
    st: RSC_HOLD, hold: RSC_HOLD_LAST, flags: 8'h02,
    en_mcd: 1'b0, en_cmp: 1'b0, en_rtc: 1'b0, en_vdm: 1'b1,
    pin_s: 3'h7, cmp_s: 3'h7, vdd_s: 3'h7, mon_s: 3'h0,
    pin_l: 1'b1, cmp_l: 1'b1, vdd_l: 1'b1, mon_l: 1'b0,
    mcd_cnt: 16'h0000, div: 4'h0, wdt_en: 1'b1, wdt_tick: 1'b0,
    sys_rst: 1'b1, rdata: 8'h00, pin_o: 1'b0, pin_oe: 1'b0};

endpackage : rsc_pkg

// >>> test/rsc_reset_source_controller_bench.sv
// self-checking bench for the reset source controller
`timescale 1ns/1ns

module rsc_reset_source_controller_bench;
  import rsc_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk_sys      = 1'b0;
  logic        rstn         = 1'b0;
  rsc_sfr_t    sfr          = '0;
  rsc_flash_t  flash        = '0;
  logic [15:0] lock_addr    = 16'h7FFF;
  logic        mon_clk      = 1'b0;
  logic        mon_run      = 1'b1;
  logic        cmp_out      = 1'b1;
  logic        cmp_wake_en  = 1'b0;
  logic        vdd_ok       = 1'b1;
  logic        rst_pin_i    = 1'b1;
  logic        wdt_ovf      = 1'b0;
  logic        wdt_disable  = 1'b0;
  logic        rtc_alarm    = 1'b0;
  logic        rtc_osc_fail = 1'b0;
  logic        low_power    = 1'b0;
  logic        sys_rst, wdt_en, wdt_tick, rst_pin_o, rst_pin_oe;
  logic [7:0]  sfr_rdata;
  int          err_total    = 0;
  int          n_compared   = 0;

  // short timeout keeps the clock loss runs brief
  rsc_reset_source_controller #(.MCD_CYC(50)) u_rsc_reset_source_controller (
    .clk_sys(clk_sys), .rstn(rstn), .sfr(sfr), .flash(flash), .lock_addr(lock_addr),
    .mon_clk(mon_clk), .cmp_out(cmp_out), .cmp_wake_en(cmp_wake_en), .vdd_ok(vdd_ok),
    .rst_pin_i(rst_pin_i), .wdt_ovf(wdt_ovf), .wdt_disable(wdt_disable),
    .rtc_alarm(rtc_alarm), .rtc_osc_fail(rtc_osc_fail), .low_power(low_power),
    .sys_rst(sys_rst), .sfr_rdata(sfr_rdata), .wdt_en(wdt_en), .wdt_tick(wdt_tick),
    .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe));

  // ----------------------------------------------------------------
  // clocks: monitored clock only runs while mon_run is set
  // ----------------------------------------------------------------
  always #2 clk_sys = ~clk_sys;
  // each level spans two samples, so the three stage sync can see it settle
  always #8 if (mon_run) mon_clk = ~mon_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic check1(input string what, input logic exp, input logic got);
    check8(what, {7'h00, exp}, {7'h00, got});
  endtask : check1

  // every drive lands one time unit after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic wr_reg(input logic [7:0] d);
    sfr.addr  = RSC_CAUSE_ADDR;
    sfr.wdata = d;
    sfr.wr    = 1'b1;
    step(1);
    sfr.wr    = 1'b0;
    step(1);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    sfr.addr = a;
    sfr.rd   = 1'b1;
    step(1);
    d        = sfr_rdata;
    sfr.rd   = 1'b0;
  endtask : rd_reg

  // bounded wait; running out ends the run as a failure
  task automatic wait_lvl(input logic lvl);
    for (int i = 0; i < 400 && sys_rst !== lvl; i++) step(1);
    if (sys_rst !== lvl) begin
      err_total++;
      $display("ERROR sys_rst wait expected %b seen %b", lvl, sys_rst);
      tally_and_finish();
    end
  endtask : wait_lvl

  task automatic expect_reset(input string what, input logic [7:0] exp);
    logic [7:0] got;
    wait_lvl(1'b1);
    check1("pin drive enable", 1'b0, rst_pin_oe);
    check1("pin drive value", 1'b0, rst_pin_o);
    check1("watchdog enable", 1'b1, wdt_en);
    wait_lvl(1'b0);
    rd_reg(RSC_CAUSE_ADDR, got);
    check8(what, exp, got);
    $display("test %s done", what);
  endtask : expect_reset

  task automatic no_reset(input string what, input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      step(1);
      if (sys_rst !== 1'b0) seen = 1'b1;
    end
    check1(what, 1'b0, seen);
    $display("test %s done", what);
  endtask : no_reset

  task automatic pulse_ovf;
    wdt_ovf = 1'b1;
    step(1);
    wdt_ovf = 1'b0;
  endtask : pulse_ovf

  // one flash access, then idle with the monitor running
  task automatic flash_hit(input rsc_flash_t f, input logic bad);
    flash = f;
    step(1);
    flash = '{vdm_on: 1'b1, default: '0};
    if (bad) expect_reset("flash fault", 8'h40);
    else no_reset("legal flash access", 12);
  endtask : flash_hit

  task automatic t_wdt_tick;
    int n;
    for (int i = 0; i < 40 && wdt_tick !== 1'b1; i++) step(1);
    n = 0;
    do begin
      step(1);
      n++;
    end while (wdt_tick !== 1'b1 && n < 40);
    check8("watchdog tick spacing", 8'h0C, n[7:0]);
  endtask : t_wdt_tick

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [7:0] d;
    flash.vdm_on = 1'b1;
    step(2);
    rstn = 1'b1;
    wait_lvl(1'b0);
    rd_reg(RSC_CAUSE_ADDR, d);
    check8("power on cause", 8'h02, d);
    t_wdt_tick();
    rd_reg(8'hEE, d);
    check8("unmapped read", 8'h00, d);
    wr_reg(8'h12);
    expect_reset("software force", 8'h10);
    low_power = 1'b1;
    pulse_ovf();
    no_reset("watchdog in low power", 20);
    low_power = 1'b0;
    pulse_ovf();
    expect_reset("watchdog overflow", 8'h08);
    t_wdt_tick();
    wr_reg(8'h06);
    wr_reg(8'h02);
    mon_run = 1'b0;
    no_reset("clock loss disabled", 100);
    mon_run = 1'b1;
    low_power = 1'b1;
    wr_reg(8'h06);
    mon_run = 1'b0;
    no_reset("clock loss in low power", 100);
    mon_run = 1'b1;
    step(8);
    low_power = 1'b0;
    step(4);
    mon_run = 1'b0;
    no_reset("clock loss before timeout", 40);
    expect_reset("clock loss", 8'h04);
    mon_run = 1'b1;
    // enable set by read-modify-write must keep the other enables
    rd_reg(RSC_CAUSE_ADDR, d);
    wr_reg(d | 8'h82);
    no_reset("read modify write", 20);
    rtc_alarm = 1'b1;
    step(1);
    rtc_alarm = 1'b0;
    expect_reset("rtc alarm", 8'h80);
    low_power = 1'b1;
    rtc_osc_fail = 1'b1;
    step(1);
    rtc_osc_fail = 1'b0;
    expect_reset("rtc fail in low power", 8'h80);
    low_power = 1'b0;
    wr_reg(8'h22);
    cmp_out = 1'b0;
    step(2);
    cmp_out = 1'b1;
    expect_reset("comparator", 8'h20);
    low_power = 1'b1;
    cmp_out = 1'b0;
    no_reset("comparator no wake", 20);
    cmp_out = 1'b1;
    step(6);
    cmp_wake_en = 1'b1;
    cmp_out = 1'b0;
    step(2);
    cmp_out = 1'b1;
    expect_reset("comparator wake", 8'h20);
    low_power = 1'b0;
    wr_reg(8'h02);
    flash_hit({6'b001001, 16'h8000}, 1'b1);
    flash_hit({6'b010001, 16'h8000}, 1'b1);
    flash_hit({6'b100101, 16'h8000}, 1'b1);
    flash_hit({6'b010011, 16'h0100}, 1'b1);
    flash_hit({6'b100100, 16'h0100}, 1'b1);
    flash_hit({6'b100101, 16'h0100}, 1'b0);
    flash_hit({6'b001001, 16'h7FFF}, 1'b0);
    rst_pin_i = 1'b0;
    step(2);
    rst_pin_i = 1'b1;
    expect_reset("pin reset", 8'h01);
    wr_reg(8'h00);
    vdd_ok = 1'b0;
    no_reset("supply monitor disabled", 20);
    vdd_ok = 1'b1;
    step(6);
    wr_reg(8'h02);
    vdd_ok = 1'b0;
    step(2);
    vdd_ok = 1'b1;
    expect_reset("supply fail", 8'h02);
    // power-on reset again in mid-run
    rstn = 1'b0;
    step(2);
    rstn = 1'b1;
    expect_reset("power on again", 8'h02);
    tally_and_finish();
  end

endmodule : rsc_reset_source_controller_bench
